// ---- dhbdc_channel.sv ----
// One bridge channel: decode, chopping, dead time, overcurrent retry.
// Assumes inputs already synchronised to clk_sys; run_en low forces off.
`timescale 1ns/1ns
module dhbdc_channel
  import dhbdc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run_en,
  input wire logic cycle_start,
  input wire logic bridge_input_one,
  input wire logic bridge_input_two,
  input wire logic sense_trip,
  input wire logic overcurrent_guard,
  output dhbdc_gates_t gates,
  output logic oc_off
);
  if (RETRY_CYCLES < 1 || RETRY_CYCLES >= (1 << CNT_W)) begin : g_bad_retry
    $error("RETRY_CYCLES out of range");
  end
  if (BLANK_CYC > 255 || DEGLITCH_CYC < 1 || DEGLITCH_CYC > 255 || DEAD_CYC < 1
      || DEAD_CYC > 31) begin : g_bad_timing
    $error("Timing count too wide for its counter");
  end

  logic chop_reg;
  logic [7:0] blank_reg;
  logic [7:0] deg_reg;
  logic [CNT_W-1:0] retry_reg;
  logic oc_reg;
  logic drive_prev_reg;
  dhbdc_level_t want_one, want_two, lvl_one_reg, lvl_two_reg;
  logic [4:0] dead_one_reg, dead_two_reg;

  logic driving;
  assign driving = bridge_input_one ^ bridge_input_two;
  // Gates really in a drive state; blanking starts here, not at the pin change
  logic drive_on;
  assign drive_on = (lvl_one_reg == DHBDC_HIGH && lvl_two_reg == DHBDC_LOW)
      || (lvl_one_reg == DHBDC_LOW && lvl_two_reg == DHBDC_HIGH);

  // Target levels from the input pair
  always_comb begin
    want_one = DHBDC_OFF;
    want_two = DHBDC_OFF;
    if (!run_en || oc_reg) begin
      want_one = DHBDC_OFF;
      want_two = DHBDC_OFF;
    end else if (chop_reg && driving) begin
      want_one = DHBDC_LOW;
      want_two = DHBDC_LOW;
    end else begin
      case ({bridge_input_one, bridge_input_two})
        2'b01: begin want_one = DHBDC_LOW; want_two = DHBDC_HIGH; end
        2'b10: begin want_one = DHBDC_HIGH; want_two = DHBDC_LOW; end
        2'b11: begin want_one = DHBDC_LOW; want_two = DHBDC_LOW; end
        default: begin want_one = DHBDC_OFF; want_two = DHBDC_OFF; end
      endcase
    end
  end

  // Chopping: trip after blanking, released at next regulation cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !run_en) begin
      drive_prev_reg <= 1'b0;
      blank_reg <= 8'h00;
      chop_reg <= 1'b0;
    end else begin
      drive_prev_reg <= drive_on;
      if (cycle_start) begin
        chop_reg <= 1'b0;
        blank_reg <= BLANK_CYC[7:0];
      end else if (drive_on && !drive_prev_reg) begin
        blank_reg <= BLANK_CYC[7:0];
      end else if (blank_reg != 8'h00) begin
        blank_reg <= blank_reg - 8'h01;
      end else if (drive_on && sense_trip) begin
        chop_reg <= 1'b1;
      end
    end
  end

  // Overcurrent deglitch and retry
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !run_en) begin
      deg_reg <= 8'h00;
      retry_reg <= '0;
      oc_reg <= 1'b0;
    end else if (oc_reg) begin
      deg_reg <= 8'h00;
      if (retry_reg == CNT_W'(1)) begin
        oc_reg <= 1'b0;
      end
      retry_reg <= retry_reg - CNT_W'(1);
    end else if (overcurrent_guard) begin
      if (deg_reg == DEGLITCH_CYC[7:0] - 8'h01) begin
        oc_reg <= 1'b1;
        retry_reg <= CNT_W'(RETRY_CYCLES);
      end
      deg_reg <= deg_reg + 8'h01;
    end else begin
      deg_reg <= 8'h00;
    end
  end

  // Dead time: a half-bridge goes off before turning on the other switch
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lvl_one_reg <= DHBDC_OFF;
      lvl_two_reg <= DHBDC_OFF;
      dead_one_reg <= 5'h00;
      dead_two_reg <= 5'h00;
    end else begin
      if (want_one == lvl_one_reg) begin
        dead_one_reg <= 5'h00;
      end else if (want_one == DHBDC_OFF || lvl_one_reg == DHBDC_OFF) begin
        if (lvl_one_reg != DHBDC_OFF || dead_one_reg == DEAD_CYC[4:0] - 5'h01
            || want_one == DHBDC_OFF) begin
          lvl_one_reg <= want_one;
          dead_one_reg <= 5'h00;
        end else begin
          dead_one_reg <= dead_one_reg + 5'h01;
        end
      end else begin
        lvl_one_reg <= DHBDC_OFF;
        dead_one_reg <= 5'h00;
      end
      if (want_two == lvl_two_reg) begin
        dead_two_reg <= 5'h00;
      end else if (want_two == DHBDC_OFF || lvl_two_reg == DHBDC_OFF) begin
        if (lvl_two_reg != DHBDC_OFF || dead_two_reg == DEAD_CYC[4:0] - 5'h01
            || want_two == DHBDC_OFF) begin
          lvl_two_reg <= want_two;
          dead_two_reg <= 5'h00;
        end else begin
          dead_two_reg <= dead_two_reg + 5'h01;
        end
      end else begin
        lvl_two_reg <= DHBDC_OFF;
        dead_two_reg <= 5'h00;
      end
    end
  end

  always_comb begin
    gates.one.high_on = (lvl_one_reg == DHBDC_HIGH);
    gates.one.low_on = (lvl_one_reg == DHBDC_LOW);
    gates.two.high_on = (lvl_two_reg == DHBDC_HIGH);
    gates.two.low_on = (lvl_two_reg == DHBDC_LOW);
  end
  assign oc_off = oc_reg;

  no_shoot_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(gates.one.high_on && gates.one.low_on))
    else $error("Half-bridge shoot-through");
  dead_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $fell(gates.one.low_on) |-> !gates.one.high_on [*8])
    else $error("Dead time too short");
  oc_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    oc_reg |=> (gates == '0) || $fell(oc_reg))
    else $error("Bridge drives during overcurrent");
  chop_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    chop_reg && !cycle_start && run_en |=> chop_reg)
    else $error("Chop released early");
  blank_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(chop_reg) |-> $past(blank_reg) == 8'h00)
    else $error("Trip during blanking");
  chop_cv: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(chop_reg));
  oc_cv: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(oc_reg));
endmodule

// ---- dhbdc_pkg.sv ----
// Package for the dual H-bridge drive control block.
// Assumes a single 50 MHz system clock; all times become cycle counts here.
package dhbdc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int REG_FREQ_KHZ = 50;
  localparam int REG_PERIOD_CYC = CLK_HZ / (REG_FREQ_KHZ * 1000);
  localparam int BLANK_NS = 3750;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_NS = 450;
  localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEGLITCH_NS = 2250;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_US = 1350;
  localparam int RETRY_CYC = RETRY_US * 1000 / CLK_NS;
  localparam int WAKE_US = 1000;
  localparam int WAKE_CYC = WAKE_US * 1000 / CLK_NS;
  localparam int CNT_W = 17;

  // Switch gates of one half-bridge
  typedef struct packed {
    logic high_on;
    logic low_on;
  } dhbdc_half_t;

  // Gate drive for one bridge
  typedef struct packed {
    dhbdc_half_t one;
    dhbdc_half_t two;
  } dhbdc_gates_t;

  // Decoded target level of one half-bridge
  typedef enum logic [1:0] {
    DHBDC_OFF,
    DHBDC_HIGH,
    DHBDC_LOW
  } dhbdc_level_t;
endpackage

// ---- dhbdc_top.sv ----
// Dual H-bridge drive control: two channels, regulation timer, sleep, faults.
// Assumes all pins asynchronous to clk_sys; gates drive external power FETs.
`timescale 1ns/1ns
module dhbdc_top
  import dhbdc_pkg::*;
#(
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sleep_input_low,
  input wire logic chan_a_input_one,
  input wire logic chan_a_input_two,
  input wire logic chan_b_input_one,
  input wire logic chan_b_input_two,
  input wire logic chan_a_sense_trip,
  input wire logic chan_b_sense_trip,
  input wire logic chan_a_overcurrent_guard,
  input wire logic chan_b_overcurrent_guard,
  input wire logic thermal_shutdown,
  input wire logic supply_low_lockout,
  output dhbdc_gates_t chan_a_gates,
  output dhbdc_gates_t chan_b_gates,
  output logic fault_output_low_o,
  output logic fault_output_low_oe
);
  if (WAKE_CYCLES < 1 || WAKE_CYCLES >= (1 << CNT_W) || REG_PERIOD_CYC < 2
      || REG_PERIOD_CYC > 1024) begin : g_bad_timing
    $error("Timing parameter out of range");
  end

  // Two-flop synchronisers for every pin
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pins, sync1_reg, sync2_reg;
  assign pins = {sleep_input_low, chan_a_input_one, chan_a_input_two,
                 chan_b_input_one, chan_b_input_two, chan_a_sense_trip,
                 chan_b_sense_trip, chan_a_overcurrent_guard,
                 chan_b_overcurrent_guard, thermal_shutdown, supply_low_lockout};
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  logic awake, a1, a2, b1, b2, a_trip, b_trip, a_oc, b_oc, hot, uv;
  assign {awake, a1, a2, b1, b2, a_trip, b_trip, a_oc, b_oc, hot, uv} = sync2_reg;

  // Wake timer; sleep holds everything in reset
  logic [CNT_W-1:0] wake_reg;
  logic ready_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !awake) begin
      wake_reg <= '0;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      wake_reg <= wake_reg + CNT_W'(1);
      if (wake_reg == CNT_W'(WAKE_CYCLES - 1)) begin
        ready_reg <= 1'b1;
      end
    end
  end

  logic shutdown;
  assign shutdown = hot || uv;
  logic run_en;
  assign run_en = ready_reg && !shutdown;

  // Regulation cycle timer
  logic [9:0] period_reg;
  logic cycle_start;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !run_en) begin
      period_reg <= 10'h000;
    end else if (period_reg == 10'(REG_PERIOD_CYC - 1)) begin
      period_reg <= 10'h000;
    end else begin
      period_reg <= period_reg + 10'h001;
    end
  end
  assign cycle_start = run_en && (period_reg == 10'h000);

  logic a_off, b_off;
  // Each channel sees only its own pins
  dhbdc_channel #(.RETRY_CYCLES(RETRY_CYCLES)) u_chan_a (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run_en(run_en),
    .cycle_start(cycle_start),
    .bridge_input_one(a1),
    .bridge_input_two(a2),
    .sense_trip(a_trip),
    .overcurrent_guard(a_oc),
    .gates(chan_a_gates),
    .oc_off(a_off)
  );
  dhbdc_channel #(.RETRY_CYCLES(RETRY_CYCLES)) u_chan_b (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run_en(run_en),
    .cycle_start(cycle_start),
    .bridge_input_one(b1),
    .bridge_input_two(b2),
    .sense_trip(b_trip),
    .overcurrent_guard(b_oc),
    .gates(chan_b_gates),
    .oc_off(b_off)
  );

  // Fault pin from a flop; only ever pulls low
  logic fault_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= a_off || b_off || (awake && shutdown);
    end
  end
  assign fault_output_low_o = 1'b0;
  assign fault_output_low_oe = fault_reg;

  sleep_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !awake |=> ##1 chan_a_gates == '0 && chan_b_gates == '0)
    else $error("Bridge active in sleep");
  wake_time_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(ready_reg) |-> $past(wake_reg) == CNT_W'(WAKE_CYCLES - 1))
    else $error("Wake time wrong");
  fault_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (a_off || b_off) |=> fault_output_low_oe)
    else $error("Fault pin not pulled");
  shut_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    shutdown |=> ##1 chan_a_gates == '0)
    else $error("Bridge on during shutdown");
  cycle_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cycle_start && run_en ##1 run_en [*7] |-> !cycle_start)
    else $error("Regulation cycle too short");
  wake_cv: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(ready_reg));
  fault_cv: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(fault_reg));
endmodule

// ---- dhbdc_ctrl_model.sv ----
// Controller model for the bridge inputs and the sleep pin.
// Assumes the bench changes mode, pwm and wake at falling edges.
`timescale 1ns/1ns
module dhbdc_ctrl_model (
  input wire logic clk_sys,
  input wire logic [1:0] mode_a,
  input wire logic [1:0] mode_b,
  input wire logic pwm_a,
  input wire logic wake,
  output logic chan_a_input_one,
  output logic chan_a_input_two,
  output logic chan_b_input_one,
  output logic chan_b_input_two,
  output logic sleep_input_low
);
  logic [5:0] pwm_cnt_reg = 6'h00;
  always_ff @(negedge clk_sys) begin
    pwm_cnt_reg <= pwm_cnt_reg + 6'h01;
  end
  // PWM on channel A input one, input two held at the decay level
  assign chan_a_input_one = pwm_a ? pwm_cnt_reg[5] : mode_a[1];
  assign chan_a_input_two = mode_a[0];
  assign chan_b_input_one = mode_b[1];
  assign chan_b_input_two = mode_b[0];
  assign sleep_input_low = wake;
endmodule

// ---- tb.sv ----
// Self-checking bench for the dual bridge drive control.
// Assumes short retry and wake counts; fault pin has a pull-up.
`timescale 1ns/1ns
module tb;
  import dhbdc_pkg::*;
  logic clk_sys;
  logic rst_b;
  logic [1:0] mode_a;
  logic [1:0] mode_b;
  logic [1:0] seen;
  logic pwm_a;
  logic wake;
  logic trip_a;
  logic oc_a;
  logic hot;
  logic uv;
  logic trip_b;
  logic oc_b;
  logic in_a1, in_a2, in_b1, in_b2, sleep_n;
  dhbdc_gates_t gates_a;
  dhbdc_gates_t gates_b;
  logic flt_o;
  logic flt_oe;
  wire fault_line = flt_oe ? flt_o : 1'b1;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n1;
  int n2;
  logic [11:0] rows [6] = '{12'h000, 12'h996, 12'h669, 12'hc50, 12'h305, 12'ha99};

  dhbdc_ctrl_model u_ctrl (.clk_sys(clk_sys), .mode_a(mode_a), .mode_b(mode_b),
    .pwm_a(pwm_a), .wake(wake), .chan_a_input_one(in_a1), .chan_a_input_two(in_a2),
    .chan_b_input_one(in_b1), .chan_b_input_two(in_b2), .sleep_input_low(sleep_n));

  dhbdc_top #(.RETRY_CYCLES(50), .WAKE_CYCLES(20)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .sleep_input_low(sleep_n), .chan_a_input_one(in_a1), .chan_a_input_two(in_a2),
    .chan_b_input_one(in_b1), .chan_b_input_two(in_b2), .chan_a_sense_trip(trip_a),
    .chan_b_sense_trip(trip_b), .chan_a_overcurrent_guard(oc_a),
    .chan_b_overcurrent_guard(oc_b), .thermal_shutdown(hot), .supply_low_lockout(uv),
    .chan_a_gates(gates_a), .chan_b_gates(gates_b), .fault_output_low_o(flt_o),
    .fault_output_low_oe(flt_oe));

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic cmp_gates(input string what, input dhbdc_gates_t exp, input dhbdc_gates_t got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Bounded wait on one channel; the count doubles as the measured interval
  task automatic wait_gates(input logic on_b, input dhbdc_gates_t want, output int n);
    n = 0;
    while ((on_b ? gates_b : gates_a) !== want && n < 1200) begin
      tick(1);
      n++;
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  initial begin
    rst_b = 1'b0;
    {mode_a, mode_b, pwm_a, trip_a, oc_a, hot, uv, trip_b, oc_b} = '0;
    wake = 1'b1;
    tick(20);
    cmp_gates("reset gates", 4'h0, gates_a);
    cmp_gates("reset gates b", 4'h0, gates_b);
    cmp_bit("reset fault", 1'b1, fault_line);
    $display("test reset done");
    rst_b = 1'b1;
    tick(40);
    foreach (rows[i]) begin
      {mode_a, mode_b} = rows[i][11:8];
      tick(35);
      cmp_gates("row gates a", rows[i][7:4], gates_a);
      cmp_gates("row gates b", rows[i][3:0], gates_b);
    end
    $display("test table done");
    mode_a = 2'b01;
    tick(12);
    cmp_gates("dead gap", 4'h0, gates_a);
    tick(30);
    cmp_gates("after dead", 4'h6, gates_a);
    $display("test dead time done");
    mode_a = 2'b10;
    tick(35);
    trip_a = 1'b1;
    wait_gates(1'b0, 4'h5, n1);
    cmp_gates("chop b free", 4'h9, gates_b);
    wait_gates(1'b0, 4'h9, n1);
    wait_gates(1'b0, 4'h5, n1);
    wait_gates(1'b0, 4'h9, n2);
    cmp_bit("blank interval", 1'b1, n1 > 150 && n1 < 230);
    cmp_bit("chop period", 1'b1, n1 + n2 == REG_PERIOD_CYC);
    cmp_bit("held off", 1'b1, n2 > 700);
    trip_a = 1'b0;
    tick(1100);
    cmp_gates("chop end", 4'h9, gates_a);
    $display("test chopping done");
    mode_b = 2'b01;
    tick(35);
    oc_a = 1'b1;
    tick(100);
    cmp_gates("deglitch", 4'h9, gates_a);
    tick(40);
    cmp_gates("oc gates a", 4'h0, gates_a);
    cmp_gates("oc gates b", 4'h6, gates_b);
    cmp_bit("oc fault", 1'b0, fault_line);
    oc_a = 1'b0;
    tick(250);
    cmp_bit("oc retry fault", 1'b1, fault_line);
    cmp_gates("oc retry gates", 4'h9, gates_a);
    $display("test overcurrent done");
    oc_b = 1'b1;
    tick(140);
    cmp_gates("oc b gates b", 4'h0, gates_b);
    cmp_gates("oc b gates a", 4'h9, gates_a);
    cmp_bit("oc b fault", 1'b0, fault_line);
    oc_b = 1'b0;
    tick(250);
    cmp_gates("oc b retry", 4'h6, gates_b);
    cmp_bit("oc b released", 1'b1, fault_line);
    trip_b = 1'b1;
    wait_gates(1'b1, 4'h5, n2);
    cmp_gates("chop b", 4'h5, gates_b);
    cmp_gates("chop a free", 4'h9, gates_a);
    trip_b = 1'b0;
    $display("test channel b done");
    for (int k = 0; k < 2; k++) begin
      {hot, uv} = k ? 2'b01 : 2'b10;
      tick(10);
      cmp_gates("shut gates", 4'h0, gates_a);
      cmp_bit("shut fault", 1'b0, fault_line);
      {hot, uv} = 2'b00;
      tick(60);
      cmp_gates("resume gates", 4'h9, gates_a);
      cmp_bit("resume fault", 1'b1, fault_line);
    end
    $display("test shutdown done");
    wake = 1'b0;
    tick(10);
    cmp_gates("sleep gates b", 4'h0, gates_b);
    mode_a = 2'b01;
    oc_a = 1'b1;
    tick(150);
    cmp_gates("sleep gates a", 4'h0, gates_a);
    cmp_bit("sleep fault", 1'b1, fault_line);
    oc_a = 1'b0;
    wake = 1'b1;
    tick(10);
    cmp_gates("waking", 4'h0, gates_a);
    tick(40);
    cmp_gates("awake", 4'h6, gates_a);
    $display("test sleep done");
    pwm_a = 1'b1;
    for (int m = 0; m < 2; m++) begin
      mode_a = m[1:0];
      seen = 2'b00;
      tick(70);
      repeat (128) begin
        tick(1);
        seen[0] = seen[0] | (gates_a === (m ? 4'h6 : 4'h9));
        seen[1] = seen[1] | (gates_a === (m ? 4'h5 : 4'h0));
      end
      cmp_bit("decay modes", 1'b1, &seen);
    end
    $display("test pwm done");
    report_and_stop();
  end
endmodule
